// *** bce_pkg.sv ***
// constants of the bridge command enable block
package bce_pkg;
   // register offsets, byte addresses on the wishbone bus
   localparam logic [7:0] BCE_OFF_CMD = 8'h00;
   localparam logic [7:0] BCE_OFF_IOWIN = 8'h04;
   localparam logic [7:0] BCE_OFF_MEMWIN = 8'h08;
   localparam logic [7:0] BCE_OFF_PREFWIN = 8'h0C;
   localparam logic [7:0] BCE_OFF_ERRCTL = 8'h10;
   localparam logic [7:0] BCE_OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] BCE_OFF_IRQ_MASK = 8'h18;
   // command field positions
   localparam int BCE_CMD_IO = 0;
   localparam int BCE_CMD_MEM = 1;
   localparam int BCE_CMD_MST = 2;
   localparam int BCE_CMD_SPC = 3;
   localparam int BCE_CMD_MWI = 4;
   localparam int BCE_CMD_PAR = 6;
   localparam int BCE_CMD_STEP = 7;
   localparam int BCE_CMD_ERRMSG = 8;
   // writable command bits and reset value
   localparam logic [15:0] BCE_CMD_WMASK = 16'h0107;
   localparam logic [15:0] BCE_CMD_RST = 16'h0000;
   // window and error control reset values
   localparam logic [7:0] BCE_IO_BASE_RST = 8'hF0;
   localparam logic [7:0] BCE_IO_LIM_RST = 8'h00;
   localparam logic [15:0] BCE_MEM_BASE_RST = 16'hFFF0;
   localparam logic [15:0] BCE_MEM_LIM_RST = 16'h0000;
   localparam logic [7:0] BCE_ERR_RST = 8'h00;
   // legacy video window
   localparam logic [31:0] BCE_VGA_LO = 32'h000A_0000;
   localparam logic [31:0] BCE_VGA_HI = 32'h000B_FFFF;
   // bridge control bit that enables secondary error forwarding
   localparam int BCE_BRIDGE_CONTROL_SERR = 1;
   // interrupt status layout
   localparam int BCE_IRQ_MABORT = 0;
   localparam int BCE_IRQ_BRG_MSG = 1;
   localparam int BCE_IRQ_HOST_MSG = 2;
   localparam int BCE_IRQ_W = 3;
   localparam logic [BCE_IRQ_W-1:0] BCE_IRQ_RST = 3'h0;
endpackage

// *** bce_win_dec.sv ***
// address window decoder for memory, prefetchable, vga and i/o space
`timescale 1ns/1ps
module bce_win_dec (
   input wire logic [31:0] addr_i,
   input wire logic is_io_i,
   input wire logic mem_en_i,
   input wire logic io_en_i,
   input wire logic [7:0] io_base_i,
   input wire logic [7:0] io_lim_i,
   input wire logic [15:0] mem_base_i,
   input wire logic [15:0] mem_lim_i,
   input wire logic [15:0] pref_base_i,
   input wire logic [15:0] pref_lim_i,
   output logic hit_o
);
   import bce_pkg::*;

   // 1 MB granular memory window test
   function automatic logic in_mem(input logic [31:0] a,
                                   input logic [15:0] b,
                                   input logic [15:0] l);
      in_mem = (a[31:20] >= b[15:4]) && (a[31:20] <= l[15:4]);
   endfunction

   logic mem_hit;
   logic io_hit;

   // memory side claims only when enabled
   // memory, prefetch and vga windows
   assign mem_hit = mem_en_i && !is_io_i &&
      (in_mem(addr_i, mem_base_i, mem_lim_i) ||
       in_mem(addr_i, pref_base_i, pref_lim_i) ||
       ((addr_i >= BCE_VGA_LO) && (addr_i <= BCE_VGA_HI)));

   // 4 KB granular i/o window in 64 KB space
   // i/o window decode
   assign io_hit = io_en_i && is_io_i && (addr_i[31:16] == 16'h0000) &&
      (addr_i[15:12] >= io_base_i[7:4]) && (addr_i[15:12] <= io_lim_i[7:4]);

   assign hit_o = mem_hit || io_hit;
endmodule

// *** bce_err_msg.sv ***
// system error message generator for bridge and host functions
`timescale 1ns/1ps
module bce_err_msg (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] brg_evt_i,
   input wire logic [7:0] error_command_i,
   input wire logic sec_serr_i,
   input wire logic [7:0] bridge_control_i,
   input wire logic bridge_err_msg_en_i,
   input wire logic host_evt_i,
   input wire logic host_err_msg_en_i,
   output logic msg_o,
   output logic brg_sent_o,
   output logic host_sent_o
);
   import bce_pkg::*;

   logic brg_cond;
   logic brg_go;
   logic host_go;

   // bridge conditions individually enabled
   // per-condition enables under bit 8
   assign brg_cond = (|(brg_evt_i & error_command_i)) ||
      (sec_serr_i && bridge_control_i[BCE_BRIDGE_CONTROL_SERR]);
   // each enable gates its own function
   assign brg_go = bridge_err_msg_en_i && brg_cond;
   assign host_go = host_err_msg_en_i && host_evt_i;

   // one message pulse per cycle with a cause
   // two enables combine by or
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         msg_o <= 1'b0;
         brg_sent_o <= 1'b0;
         host_sent_o <= 1'b0;
      end else begin
         msg_o <= brg_go || host_go;
         brg_sent_o <= brg_go;
         host_sent_o <= host_go;
      end
   end
endmodule

// *** bce_top.sv ***
// bridge command enables with wishbone registers and cycle gating
`timescale 1ns/1ps
// Summary of operation
// - error message if either enable set
// - bridge enable gates bridge errors only
// - stepping bit 7 reads zero
// - parity enable bit 6 hardwired zero
// - bits 4 and 3 read zero
// - master enable accepts decoded frame cycles
// - sideband requests ignore enable
// - master enable clear aborts frame cycles
// - memory enable decodes memory windows
// - memory disabled claims no memory
// - i/o enable decodes i/o window
// - i/o disabled claims no i/o
// - bit 8 permits enabled bridge errors
module bce_top (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // primary side access to the bridge windows
   input wire logic pri_req_i,
   input wire logic [31:0] pri_addr_i,
   input wire logic pri_is_io_i,
   output logic pri_claim_o,
   // secondary master cycles
   input wire logic sec_frame_i,
   input wire logic [31:0] sec_addr_i,
   input wire logic sec_is_io_i,
   input wire logic sec_sba_i,
   output logic sec_accept_o,
   output logic sec_mabort_o,
   output logic sec_sba_ack_o,
   // error sources and message
   input wire logic [7:0] brg_evt_i,
   input wire logic sec_serr_i,
   input wire logic host_evt_i,
   input wire logic host_err_msg_en_i,
   output logic serr_msg_o,
   output logic irq_o
);
   import bce_pkg::*;

   logic [15:0] cmd_r;
   logic [7:0] io_base_r;
   logic [7:0] io_lim_r;
   logic [15:0] mem_base_r;
   logic [15:0] mem_lim_r;
   logic [15:0] pref_base_r;
   logic [15:0] pref_lim_r;
   logic [7:0] err_cmd_r;
   logic [7:0] bridge_control_r;
   logic [BCE_IRQ_W-1:0] irq_stat_r;
   logic [BCE_IRQ_W-1:0] irq_mask_r;
   logic [31:0] rd_nxt;
   logic wb_req;
   logic wb_wr;
   logic pri_hit;
   logic sec_dn_hit;
   logic sec_ok;
   logic brg_sent;
   logic host_sent;
   logic [BCE_IRQ_W-1:0] irq_evt;
   logic [31:0] cmd_mrg;
   logic [31:0] iowin_mrg;
   logic [31:0] errctl_mrg;

   // byte lane merge under a field write mask
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] sel,
                                         input logic [31:0] wm);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wm;
      merge = (old & ~m) | (wd & m);
   endfunction

   // merged write values for the 16-bit registers
   assign cmd_mrg = merge({16'h0000, cmd_r}, wb_dat_i, wb_sel_i,
      {16'h0000, BCE_CMD_WMASK});
   assign iowin_mrg = merge({16'h0000, io_lim_r, io_base_r}, wb_dat_i,
      wb_sel_i, 32'h0000_FFFF);
   assign errctl_mrg = merge({16'h0000, bridge_control_r, err_cmd_r}, wb_dat_i,
      wb_sel_i, 32'h0000_FFFF);

   // new request, taken once per classic cycle
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_wr = wb_req && wb_we_i;

   // acknowledge one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // command register, enable bits only
   // only enable bits take writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_r <= BCE_CMD_RST;
      end else if (wb_wr && wb_adr_i == BCE_OFF_CMD) begin
         cmd_r <= cmd_mrg[15:0];
      end
   end

   // window registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         io_base_r <= BCE_IO_BASE_RST;
         io_lim_r <= BCE_IO_LIM_RST;
         mem_base_r <= BCE_MEM_BASE_RST;
         mem_lim_r <= BCE_MEM_LIM_RST;
         pref_base_r <= BCE_MEM_BASE_RST;
         pref_lim_r <= BCE_MEM_LIM_RST;
      end else if (wb_wr) begin
         case (wb_adr_i)
            BCE_OFF_IOWIN: begin
               {io_lim_r, io_base_r} <= iowin_mrg[15:0];
            end
            BCE_OFF_MEMWIN: begin
               {mem_lim_r, mem_base_r} <= merge({mem_lim_r, mem_base_r},
                  wb_dat_i, wb_sel_i, 32'hFFFF_FFFF);
            end
            BCE_OFF_PREFWIN: begin
               {pref_lim_r, pref_base_r} <= merge({pref_lim_r,
                  pref_base_r}, wb_dat_i, wb_sel_i, 32'hFFFF_FFFF);
            end
            default: begin
            end
         endcase
      end
   end

   // error command and bridge control enables
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_cmd_r <= BCE_ERR_RST;
         bridge_control_r <= BCE_ERR_RST;
      end else if (wb_wr && wb_adr_i == BCE_OFF_ERRCTL) begin
         {bridge_control_r, err_cmd_r} <= errctl_mrg[15:0];
      end
   end

   // interrupt mask register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_r <= BCE_IRQ_RST;
      end else if (wb_wr && wb_adr_i == BCE_OFF_IRQ_MASK && wb_sel_i[0]) begin
         irq_mask_r <= wb_dat_i[BCE_IRQ_W-1:0];
      end
   end

   // sticky status, set wins over write-one clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_r <= BCE_IRQ_RST;
      end else if (wb_wr && wb_adr_i == BCE_OFF_IRQ_STAT && wb_sel_i[0]) begin
         irq_stat_r <= (irq_stat_r & ~wb_dat_i[BCE_IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat_r <= irq_stat_r | irq_evt;
      end
   end

   // level interrupt from unmasked status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_r & irq_mask_r);
      end
   end

   // read mux; hardwired command bits show zero
   // stepping bit reads zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (wb_adr_i)
         BCE_OFF_CMD: rd_nxt = {16'h0000, cmd_r & BCE_CMD_WMASK};
         BCE_OFF_IOWIN: rd_nxt = {16'h0000, io_lim_r, io_base_r};
         BCE_OFF_MEMWIN: rd_nxt = {mem_lim_r, mem_base_r};
         BCE_OFF_PREFWIN: rd_nxt = {pref_lim_r, pref_base_r};
         BCE_OFF_ERRCTL: rd_nxt = {16'h0000, bridge_control_r, err_cmd_r};
         BCE_OFF_IRQ_STAT: rd_nxt = {29'h0000_0000, irq_stat_r};
         BCE_OFF_IRQ_MASK: rd_nxt = {29'h0000_0000, irq_mask_r};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // read data registered with the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         wb_dat_o <= rd_nxt;
      end else begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

   // primary access claim against the bridge windows
   bce_win_dec u_pri_dec (
      .addr_i(pri_addr_i),
      .is_io_i(pri_is_io_i),
      .mem_en_i(cmd_r[BCE_CMD_MEM]),
      .io_en_i(cmd_r[BCE_CMD_IO]),
      .io_base_i(io_base_r),
      .io_lim_i(io_lim_r),
      .mem_base_i(mem_base_r),
      .mem_lim_i(mem_lim_r),
      .pref_base_i(pref_base_r),
      .pref_lim_i(pref_lim_r),
      .hit_o(pri_hit)
   );

   // secondary cycle inside the windows stays downstream
   bce_win_dec u_sec_dec (
      .addr_i(sec_addr_i),
      .is_io_i(sec_is_io_i),
      .mem_en_i(cmd_r[BCE_CMD_MEM]),
      .io_en_i(cmd_r[BCE_CMD_IO]),
      .io_base_i(io_base_r),
      .io_lim_i(io_lim_r),
      .mem_base_i(mem_base_r),
      .mem_lim_i(mem_lim_r),
      .pref_base_i(pref_base_r),
      .pref_lim_i(pref_lim_r),
      .hit_o(sec_dn_hit)
   );

   // accept decoded frame cycles when enabled
   assign sec_ok = cmd_r[BCE_CMD_MST] && !sec_dn_hit;

   // cycle answers, one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pri_claim_o <= 1'b0;
         sec_accept_o <= 1'b0;
         sec_mabort_o <= 1'b0;
         sec_sba_ack_o <= 1'b0;
      end else begin
         // no claim without a window hit
         pri_claim_o <= pri_req_i && pri_hit;
         sec_accept_o <= sec_frame_i && sec_ok;
         // disabled master ends in master abort
         sec_mabort_o <= sec_frame_i && !sec_ok;
         sec_sba_ack_o <= sec_sba_i;
      end
   end

   // system error message path
   bce_err_msg u_err (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .brg_evt_i(brg_evt_i),
      .error_command_i(err_cmd_r),
      .sec_serr_i(sec_serr_i),
      .bridge_control_i(bridge_control_r),
      .bridge_err_msg_en_i(cmd_r[BCE_CMD_ERRMSG]),
      .host_evt_i(host_evt_i),
      .host_err_msg_en_i(host_err_msg_en_i),
      .msg_o(serr_msg_o),
      .brg_sent_o(brg_sent),
      .host_sent_o(host_sent)
   );

   // interrupt events
   assign irq_evt = {host_sent, brg_sent, sec_mabort_o};

   // checks next to the logic
   property p_cmd_hardwired;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == BCE_OFF_CMD |->
         wb_dat_o[7:3] == 5'h00 && wb_dat_o[15:9] == 7'h00;
   endproperty
   a_cmd_hardwired: assert property (p_cmd_hardwired)
      else $error("hardwired command bit read nonzero");

   property p_cmd_wmask;
      @(posedge clk_i) disable iff (rst_i)
      (cmd_r & ~BCE_CMD_WMASK) == 16'h0000;
   endproperty
   a_cmd_wmask: assert property (p_cmd_wmask)
      else $error("non-writable command bit set");

   property p_accept;
      @(posedge clk_i) disable iff (rst_i)
      sec_frame_i && cmd_r[BCE_CMD_MST] && !sec_dn_hit |=> sec_accept_o;
   endproperty
   a_accept: assert property (p_accept)
      else $error("enabled decoded frame cycle not accepted");

   property p_abort;
      @(posedge clk_i) disable iff (rst_i)
      sec_frame_i && !cmd_r[BCE_CMD_MST] |=> sec_mabort_o && !sec_accept_o;
   endproperty
   a_abort: assert property (p_abort)
      else $error("disabled master cycle not aborted");

   property p_sba;
      @(posedge clk_i) disable iff (rst_i)
      sec_sba_i |=> sec_sba_ack_o;
   endproperty
   a_sba: assert property (p_sba)
      else $error("sideband request not answered");

   property p_mem_off;
      @(posedge clk_i) disable iff (rst_i)
      pri_req_i && !pri_is_io_i && !cmd_r[BCE_CMD_MEM] |=> !pri_claim_o;
   endproperty
   a_mem_off: assert property (p_mem_off)
      else $error("memory claimed while disabled");

   property p_io_off;
      @(posedge clk_i) disable iff (rst_i)
      pri_req_i && pri_is_io_i && !cmd_r[BCE_CMD_IO] |=> !pri_claim_o;
   endproperty
   a_io_off: assert property (p_io_off)
      else $error("i/o claimed while disabled");

   property p_vga;
      @(posedge clk_i) disable iff (rst_i)
      pri_req_i && !pri_is_io_i && cmd_r[BCE_CMD_MEM] &&
         pri_addr_i == BCE_VGA_LO |=> pri_claim_o;
   endproperty
   a_vga: assert property (p_vga)
      else $error("vga window not claimed");

   property p_host_msg;
      @(posedge clk_i) disable iff (rst_i)
      host_evt_i && host_err_msg_en_i |=> serr_msg_o;
   endproperty
   a_host_msg: assert property (p_host_msg)
      else $error("host error message missing");

   property p_brg_gate;
      @(posedge clk_i) disable iff (rst_i)
      !cmd_r[BCE_CMD_ERRMSG] && !(host_evt_i && host_err_msg_en_i)
         |=> !serr_msg_o;
   endproperty
   a_brg_gate: assert property (p_brg_gate)
      else $error("bridge message sent while disabled");

   c_accept: cover property (@(posedge clk_i) disable iff (rst_i)
      sec_accept_o);
   c_abort: cover property (@(posedge clk_i) disable iff (rst_i)
      sec_mabort_o ##1 irq_o);
   c_claim: cover property (@(posedge clk_i) disable iff (rst_i)
      pri_claim_o);
   c_msg: cover property (@(posedge clk_i) disable iff (rst_i)
      serr_msg_o);
endmodule

// *** bce_gfx_master.sv ***
// graphics master model for the secondary frame and sideband requests
`timescale 1ns/1ps
module bce_gfx_master (
   input wire logic clk_i,
   output logic sec_frame_o,
   output logic [31:0] sec_addr_o,
   output logic sec_is_io_o,
   output logic sec_sba_o
);
   // idle bus at time zero
   initial begin
      sec_frame_o = 1'b0;
      sec_addr_o = 32'h5A5A_5A5A;
      sec_is_io_o = 1'b0;
      sec_sba_o = 1'b0;
   end

   // one frame cycle after gap idle cycles, address scrambled afterwards
   task automatic frame(input int gap, input logic [31:0] a,
         input logic io);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      sec_frame_o <= 1'b1;
      sec_addr_o <= a;
      sec_is_io_o <= io;
      @(posedge clk_i);
      sec_frame_o <= 1'b0;
      sec_addr_o <= ~a;
      sec_is_io_o <= ~io;
   endtask

   // one sideband request after gap idle cycles
   task automatic sideband(input int gap);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      sec_sba_o <= 1'b1;
      @(posedge clk_i);
      sec_sba_o <= 1'b0;
   endtask
endmodule

// *** testbench.sv ***
// self-checking testbench for the bridge command enables
`timescale 1ns/1ps
module testbench;
   import bce_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i, brg_evt_i;
   logic [31:0] wb_dat_i, wb_dat_o, pri_addr_i, sec_addr_i, rd;
   logic [3:0] wb_sel_i;
   logic pri_req_i, pri_is_io_i, pri_claim_o, sec_frame_i, sec_is_io_i;
   logic sec_sba_i, sec_accept_o, sec_mabort_o, sec_sba_ack_o;
   logic sec_serr_i, host_evt_i, host_err_msg_en_i, serr_msg_o, irq_o;
   int error_cnt, n_tests;

   bce_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pri_req_i(pri_req_i), .pri_addr_i(pri_addr_i),
      .pri_is_io_i(pri_is_io_i), .pri_claim_o(pri_claim_o),
      .sec_frame_i(sec_frame_i), .sec_addr_i(sec_addr_i),
      .sec_is_io_i(sec_is_io_i), .sec_sba_i(sec_sba_i),
      .sec_accept_o(sec_accept_o), .sec_mabort_o(sec_mabort_o),
      .sec_sba_ack_o(sec_sba_ack_o), .brg_evt_i(brg_evt_i),
      .sec_serr_i(sec_serr_i), .host_evt_i(host_evt_i),
      .host_err_msg_en_i(host_err_msg_en_i), .serr_msg_o(serr_msg_o),
      .irq_o(irq_o));

   bce_gfx_master i_gfx (.clk_i(clk_i), .sec_frame_o(sec_frame_i),
      .sec_addr_o(sec_addr_i), .sec_is_io_o(sec_is_io_i),
      .sec_sba_o(sec_sba_i));

   // 50 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // compare and count
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // counts, verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // classic wishbone cycle, waits for ack under a bound
   task automatic wb(input logic we, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED wb_ack expected 1 seen timeout");
         summarize();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      wb_dat_i <= ~d;
   endtask

   task automatic rdc(input string what, input logic [7:0] a,
         input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      check(what, rd, exp);
   endtask

   // primary access pulse and claim check
   task automatic pri(input logic [31:0] a, input logic io,
         input logic exp);
      @(posedge clk_i);
      pri_req_i <= 1'b1;
      pri_addr_i <= a;
      pri_is_io_i <= io;
      @(posedge clk_i);
      pri_req_i <= 1'b0;
      pri_addr_i <= ~a;
      pri_is_io_i <= ~io;
      #1 check("pri_claim", {31'h0, pri_claim_o}, {31'h0, exp});
   endtask

   // error cause pulse and message check
   task automatic err(input logic [7:0] b, input logic s, input logic h,
         input logic exp);
      @(posedge clk_i);
      brg_evt_i <= b;
      sec_serr_i <= s;
      host_evt_i <= h;
      @(posedge clk_i);
      brg_evt_i <= 8'h00;
      sec_serr_i <= 1'b0;
      host_evt_i <= 1'b0;
      #1 check("serr_msg", {31'h0, serr_msg_o}, {31'h0, exp});
   endtask

   task automatic t_regs();
      rdc("cmd_rst", BCE_OFF_CMD, 32'h0000_0000);
      rdc("iowin_rst", BCE_OFF_IOWIN, 32'h0000_00F0);
      rdc("memwin_rst", BCE_OFF_MEMWIN, 32'h0000_FFF0);
      rdc("prefwin_rst", BCE_OFF_PREFWIN, 32'h0000_FFF0);
      rdc("mask_rst", BCE_OFF_IRQ_MASK, 32'h0000_0000);
      wb(1'b1, BCE_OFF_CMD, 32'hFFFF_FFFF);
      rdc("cmd_ones", BCE_OFF_CMD, 32'h0000_0107);
      wb(1'b1, 8'h20, 32'hFFFF_FFFF);
      rdc("unmapped", 8'h20, 32'h0000_0000);
      rdc("cmd_kept", BCE_OFF_CMD, 32'h0000_0107);
      wb(1'b1, BCE_OFF_CMD, 32'h0000_0000);
      rdc("cmd_zero", BCE_OFF_CMD, 32'h0000_0000);
      $display("register test done");
   endtask

   task automatic t_master();
      i_gfx.frame(0, 32'h2000_0000, 1'b0);
      #1 check("mabort_off", {31'h0, sec_mabort_o}, 32'h1);
      check("accept_off", {31'h0, sec_accept_o}, 32'h0);
      repeat (2) @(posedge clk_i);
      #1 check("irq_masked", {31'h0, irq_o}, 32'h0);
      i_gfx.sideband(3);
      #1 check("sba_off", {31'h0, sec_sba_ack_o}, 32'h1);
      wb(1'b1, BCE_OFF_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      #1 check("irq_set", {31'h0, irq_o}, 32'h1);
      rdc("irq_stat", BCE_OFF_IRQ_STAT, 32'h0000_0001);
      wb(1'b1, BCE_OFF_IRQ_STAT, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      #1 check("irq_clr", {31'h0, irq_o}, 32'h0);
      wb(1'b1, BCE_OFF_CMD, 32'h0000_0004);
      i_gfx.frame(2, 32'h2000_0000, 1'b0);
      #1 check("accept_on", {31'h0, sec_accept_o}, 32'h1);
      i_gfx.frame(0, 32'h3000_0000, 1'b0);
      #1 check("accept_b2b", {31'h0, sec_accept_o}, 32'h1);
      i_gfx.sideband(0);
      #1 check("sba_on", {31'h0, sec_sba_ack_o}, 32'h1);
      $display("master test done");
   endtask

   task automatic t_decode();
      wb(1'b1, BCE_OFF_CMD, 32'h0000_0000);
      wb(1'b1, BCE_OFF_IOWIN, 32'h0000_2010);
      wb(1'b1, BCE_OFF_MEMWIN, 32'h0030_0010);
      wb(1'b1, BCE_OFF_PREFWIN, 32'h0060_0050);
      rdc("memwin", BCE_OFF_MEMWIN, 32'h0030_0010);
      pri(32'h000A_0000, 1'b0, 1'b0);
      pri(32'h0020_0000, 1'b0, 1'b0);
      pri(32'h0000_1800, 1'b1, 1'b0);
      wb(1'b1, BCE_OFF_CMD, 32'h0000_0003);
      pri(32'h000A_0000, 1'b0, 1'b1);
      pri(32'h000B_FFFF, 1'b0, 1'b1);
      pri(32'h0020_0000, 1'b0, 1'b1);
      pri(32'h0040_0000, 1'b0, 1'b0);
      pri(32'h0055_0000, 1'b0, 1'b1);
      pri(32'h0000_1800, 1'b1, 1'b1);
      pri(32'h0000_3000, 1'b1, 1'b0);
      wb(1'b1, BCE_OFF_CMD, 32'h0000_0007);
      i_gfx.frame(0, 32'h0020_0000, 1'b0);
      #1 check("mabort_dn", {31'h0, sec_mabort_o}, 32'h1);
      check("accept_dn", {31'h0, sec_accept_o}, 32'h0);
      $display("decode test done");
   endtask

   task automatic t_err();
      @(posedge clk_i);
      host_err_msg_en_i <= 1'b1;
      err(8'h00, 1'b0, 1'b1, 1'b1);
      wb(1'b1, BCE_OFF_ERRCTL, 32'h0000_0201);
      wb(1'b1, BCE_OFF_CMD, 32'h0000_0000);
      err(8'h01, 1'b0, 1'b0, 1'b0);
      @(posedge clk_i);
      host_err_msg_en_i <= 1'b0;
      err(8'h00, 1'b0, 1'b1, 1'b0);
      wb(1'b1, BCE_OFF_CMD, 32'h0000_0100);
      err(8'h01, 1'b0, 1'b0, 1'b1);
      err(8'h02, 1'b0, 1'b0, 1'b0);
      err(8'h00, 1'b1, 1'b0, 1'b1);
      err(8'h00, 1'b0, 1'b1, 1'b0);
      rdc("irq_stat_all", BCE_OFF_IRQ_STAT, 32'h0000_0007);
      $display("error message test done");
   endtask

   // main sequence
   initial begin
      error_cnt = 0;
      n_tests = 0;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0000_0000;
      wb_sel_i = 4'hF;
      pri_req_i = 1'b0;
      pri_addr_i = 32'h0000_0000;
      pri_is_io_i = 1'b0;
      brg_evt_i = 8'h00;
      sec_serr_i = 1'b0;
      host_evt_i = 1'b0;
      host_err_msg_en_i = 1'b0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_master();
      t_decode();
      t_err();
      summarize();
   end
endmodule
